// >>> fes_host.sv
`timescale 1ns/100ps
// Summary of operation
// - Erase is two back-to-back writes of command 20h.
// - Before erasing, every byte is programmed to 00h.
// - Erase verify writes 0A0h with the address, reads, compares against 0FFh.
// - Erase verify starts at 0000h and walks up to the last address.
// - On verify mismatch, erase again and resume at the failing address.
// - Erase attempts are bounded, 1000 or 6000 by temperature grade.
// - Each byte gets at most 25 program pulses before failing.
// - Command 0C0h sets up program verify; next read is compared with intent.
// - At least 10 us passes after the data write before program verify.
// - At least 9.5 ms passes after the erase start write before erase verify.
// - At least 6 us passes from strobe release to output enable on verify.
module fes_host #(
  parameter int ADDR_W      = fes_pkg::ADDR_W_DEF,
  parameter int PROG_MAX    = fes_pkg::PROG_LIMIT,
  parameter int ERASE_MAX   = fes_pkg::ERASE_LIMIT_GRADE1,
  parameter int ERASE_WAIT  = fes_pkg::ERASE_CYC
) (
  input  wire logic              mclk_in,
  input  wire logic              reset_in,
  input  wire logic              clk_en_in,
  input  wire logic              cmd_valid_in,
  input  wire logic              cmd_erase_in,
  input  wire logic [ADDR_W-1:0] cmd_addr_in,
  input  wire logic [7:0]        cmd_data_in,
  output logic                   cmd_ready_out,
  output logic                   done_out,
  output logic                   fail_out,
  output logic [ADDR_W-1:0]      fail_addr_out,
  output logic                   flash_vpp_en_out,
  output logic                   flash_ce_n_out,
  output logic                   flash_oe_n_out,
  output logic                   flash_we_n_out,
  output logic [ADDR_W-1:0]      flash_addr_out,
  output logic [7:0]             flash_dq_out,
  output logic                   flash_dq_oe_out,
  input  wire logic [7:0]        flash_dq_in
);
  localparam int CW = fes_pkg::CNT_W;
  localparam int PW = fes_pkg::PULSE_W;
  localparam int RW = fes_pkg::RETRY_W;

  if (ADDR_W < 1 || ADDR_W > 24 || PROG_MAX < 1 || PROG_MAX >= 2**PW || ERASE_MAX < 1 ||
      ERASE_MAX >= 2**RW || ERASE_WAIT < 1 || ERASE_WAIT >= 2**CW) begin : g_bad_param
    $error("fes_host parameter out of range");
  end

  localparam logic [CW-1:0]     WC_LAST  = CW'(fes_pkg::WC_CYC - 1);
  localparam logic [CW-1:0]     WE_FALL  = CW'(2);
  localparam logic [CW-1:0]     WE_RISE  = CW'(2 + fes_pkg::WP_CYC);
  localparam logic [CW-1:0]     RD_LAST  = CW'(fes_pkg::RD_LEN - 1);
  localparam logic [CW-1:0]     RD_SMPL  = CW'(fes_pkg::RD_LEN - 2);
  localparam logic [CW-1:0]     VPP_LAST = CW'(fes_pkg::VPP_CYC - 1);
  localparam logic [CW-1:0]     PRG_LAST = CW'(fes_pkg::PROG_CYC - 1);
  localparam logic [CW-1:0]     VER_LAST = CW'(fes_pkg::VERIFY_CYC - 1);
  localparam logic [CW-1:0]     ERS_LAST = CW'(ERASE_WAIT - 1);
  localparam logic [PW-1:0]     PULSE_LIM = PW'(PROG_MAX);
  localparam logic [RW-1:0]     RETRY_LIM = RW'(ERASE_MAX);
  localparam logic [ADDR_W-1:0] ADDR_TOP  = '1;

  fes_pkg::fes_state_t state_q, state_d;
  logic [CW-1:0]     cnt_q, cnt_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [7:0]        data_q, data_d;
  logic [7:0]        rdata_q, rdata_d;
  logic              erase_q, erase_d;
  logic [PW-1:0]     pulse_q, pulse_d;
  logic [RW-1:0]     retry_q, retry_d;
  logic              done_d, fail_d;
  logic [ADDR_W-1:0] fail_addr_d;
  logic              vpp_d, ce_n_d, oe_n_d, we_n_d, dq_oe_d;
  logic [7:0]        dq_d;
  logic              is_wr, is_rd, wr_end;

  // Write pins and the byte put on the bus for each write state.
  always_comb begin
    is_wr = 1'b1;
    dq_d  = fes_pkg::CMD_READ;
    case (state_q)
      fes_pkg::S_P_SETUP: dq_d = fes_pkg::CMD_PROGRAM;
      fes_pkg::S_P_DATA:  dq_d = data_q;
      fes_pkg::S_P_VCMD:  dq_d = fes_pkg::CMD_PROGRAM_VERIFY;
      fes_pkg::S_E_SETUP: dq_d = fes_pkg::CMD_ERASE;
      fes_pkg::S_E_START: dq_d = fes_pkg::CMD_ERASE;
      fes_pkg::S_E_VCMD:  dq_d = fes_pkg::CMD_ERASE_VERIFY;
      fes_pkg::S_RST_CMD: dq_d = fes_pkg::CMD_READ;
      default:   is_wr = 1'b0;
    endcase
    is_rd   = (state_q == fes_pkg::S_P_READ) || (state_q == fes_pkg::S_E_READ);
    wr_end  = is_wr && (cnt_q == WC_LAST);
    vpp_d   = (state_q != fes_pkg::S_IDLE) && (state_q != fes_pkg::S_DONE);
    dq_oe_d = is_wr;
    // Strobe sits inside chip select so the strobe edges frame the cycle.
    ce_n_d  = !((is_wr && cnt_q >= CW'(1) && cnt_q < WC_LAST) || (is_rd && cnt_q < RD_LAST));
    we_n_d  = !(is_wr && cnt_q >= WE_FALL && cnt_q < WE_RISE);
    oe_n_d  = !(is_rd && cnt_q < RD_LAST);
  end

  // Algorithm sequencing.
  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q + CW'(1);
    addr_d      = addr_q;
    data_d      = data_q;
    rdata_d     = rdata_q;
    erase_d     = erase_q;
    pulse_d     = pulse_q;
    retry_d     = retry_q;
    done_d      = 1'b0;
    fail_d      = fail_out;
    fail_addr_d = fail_addr_out;
    if (is_rd && cnt_q == RD_SMPL) begin
      rdata_d = flash_dq_in;
    end
    case (state_q)
      fes_pkg::S_IDLE: begin
        if (cmd_valid_in) begin
          erase_d = cmd_erase_in;
          addr_d  = cmd_erase_in ? '0 : cmd_addr_in;
          data_d  = cmd_erase_in ? fes_pkg::DATA_ZERO : cmd_data_in;
          pulse_d = '0;
          retry_d = '0;
          fail_d  = 1'b0;
          state_d = fes_pkg::S_VPP;
        end
      end
      fes_pkg::S_VPP:     if (cnt_q == VPP_LAST) state_d = fes_pkg::S_P_SETUP;
      fes_pkg::S_P_SETUP: if (wr_end) state_d = fes_pkg::S_P_DATA;
      fes_pkg::S_P_DATA: begin
        if (wr_end) begin
          pulse_d = pulse_q + PW'(1);
          state_d = fes_pkg::S_P_WAIT;
        end
      end
      fes_pkg::S_P_WAIT:  if (cnt_q == PRG_LAST) state_d = fes_pkg::S_P_VCMD;
      fes_pkg::S_P_VCMD:  if (wr_end) state_d = fes_pkg::S_P_VWAIT;
      fes_pkg::S_P_VWAIT: if (cnt_q == VER_LAST) state_d = fes_pkg::S_P_READ;
      fes_pkg::S_P_READ:  if (cnt_q == RD_LAST) state_d = fes_pkg::S_P_CHECK;
      fes_pkg::S_P_CHECK: begin
        if (rdata_q == data_q) begin
          pulse_d = '0;
          if (!erase_q) begin
            state_d = fes_pkg::S_RST_CMD;
          end else if (addr_q == ADDR_TOP) begin
            addr_d  = '0;
            state_d = fes_pkg::S_E_SETUP;
          end else begin
            addr_d  = addr_q + ADDR_W'(1);
            state_d = fes_pkg::S_P_SETUP;
          end
        end else if (pulse_q >= PULSE_LIM) begin
          fail_d      = 1'b1;
          fail_addr_d = addr_q;
          state_d     = fes_pkg::S_RST_CMD;
        end else begin
          state_d = fes_pkg::S_P_SETUP;
        end
      end
      fes_pkg::S_E_SETUP: if (wr_end) state_d = fes_pkg::S_E_START;
      fes_pkg::S_E_START: begin
        if (wr_end) begin
          retry_d = retry_q + RW'(1);
          state_d = fes_pkg::S_E_WAIT;
        end
      end
      fes_pkg::S_E_WAIT:  if (cnt_q == ERS_LAST) state_d = fes_pkg::S_E_VCMD;
      fes_pkg::S_E_VCMD:  if (wr_end) state_d = fes_pkg::S_E_VWAIT;
      fes_pkg::S_E_VWAIT: if (cnt_q == VER_LAST) state_d = fes_pkg::S_E_READ;
      fes_pkg::S_E_READ:  if (cnt_q == RD_LAST) state_d = fes_pkg::S_E_CHECK;
      fes_pkg::S_E_CHECK: begin
        if (rdata_q == fes_pkg::DATA_ERASED) begin
          if (addr_q == ADDR_TOP) begin
            state_d = fes_pkg::S_RST_CMD;
          end else begin
            addr_d  = addr_q + ADDR_W'(1);
            state_d = fes_pkg::S_E_VCMD;
          end
        end else if (retry_q >= RETRY_LIM) begin
          fail_d      = 1'b1;
          fail_addr_d = addr_q;
          state_d     = fes_pkg::S_RST_CMD;
        end else begin
          state_d = fes_pkg::S_E_SETUP;
        end
      end
      fes_pkg::S_RST_CMD: if (wr_end) state_d = fes_pkg::S_DONE;
      fes_pkg::S_DONE: begin
        done_d  = 1'b1;
        state_d = fes_pkg::S_IDLE;
      end
      default:   state_d = fes_pkg::S_IDLE;
    endcase
    if (state_d != state_q) begin
      cnt_d = '0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_q          <= fes_pkg::S_IDLE;
      cnt_q            <= '0;
      addr_q           <= '0;
      data_q           <= '0;
      rdata_q          <= '0;
      erase_q          <= 1'b0;
      pulse_q          <= '0;
      retry_q          <= '0;
      done_out         <= 1'b0;
      fail_out         <= 1'b0;
      fail_addr_out    <= '0;
      flash_vpp_en_out <= 1'b0;
      flash_ce_n_out   <= 1'b1;
      flash_oe_n_out   <= 1'b1;
      flash_we_n_out   <= 1'b1;
      flash_addr_out   <= '0;
      flash_dq_out     <= '0;
      flash_dq_oe_out  <= 1'b0;
    end else if (clk_en_in) begin
      state_q          <= state_d;
      cnt_q            <= cnt_d;
      addr_q           <= addr_d;
      data_q           <= data_d;
      rdata_q          <= rdata_d;
      erase_q          <= erase_d;
      pulse_q          <= pulse_d;
      retry_q          <= retry_d;
      done_out         <= done_d;
      fail_out         <= fail_d;
      fail_addr_out    <= fail_addr_d;
      flash_vpp_en_out <= vpp_d;
      flash_ce_n_out   <= ce_n_d;
      flash_oe_n_out   <= oe_n_d;
      flash_we_n_out   <= we_n_d;
      flash_addr_out   <= addr_q;
      flash_dq_out     <= dq_d;
      flash_dq_oe_out  <= dq_oe_d;
    end
  end

  assign cmd_ready_out = (state_q == fes_pkg::S_IDLE);

  sequence s_strobe_low;
    !flash_we_n_out [*6];
  endsequence

  property p_strobe_width;
    @(posedge mclk_in) disable iff (reset_in) $fell(flash_we_n_out) |-> s_strobe_low;
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("write strobe too short");

  property p_we_in_ce;
    @(posedge mclk_in) disable iff (reset_in) !flash_we_n_out |-> !flash_ce_n_out && flash_oe_n_out;
  endproperty
  a_we_in_ce: assert property (p_we_in_ce) else $error("strobe outside chip select");

  property p_ce_needs_vpp;
    @(posedge mclk_in) disable iff (reset_in) !flash_ce_n_out |-> flash_vpp_en_out;
  endproperty
  a_ce_needs_vpp: assert property (p_ce_needs_vpp) else $error("bus cycle without supply");

  property p_prog_wait;
    @(posedge mclk_in) disable iff (reset_in)
      $rose(state_q == fes_pkg::S_P_VCMD) |-> $past(state_q) == fes_pkg::S_P_WAIT && $past(cnt_q) == PRG_LAST;
  endproperty
  a_prog_wait: assert property (p_prog_wait) else $error("program wait cut short");

  property p_erase_wait;
    @(posedge mclk_in) disable iff (reset_in)
      $rose(state_q == fes_pkg::S_E_VCMD) |-> $past(state_q) == fes_pkg::S_E_CHECK || $past(cnt_q) == ERS_LAST;
  endproperty
  a_erase_wait: assert property (p_erase_wait) else $error("erase wait cut short");

  property p_verify_gap;
    @(posedge mclk_in) disable iff (reset_in)
      $fell(flash_oe_n_out) |-> $past(state_q) == fes_pkg::S_P_READ || $past(state_q) == fes_pkg::S_E_READ;
  endproperty
  a_verify_gap: assert property (p_verify_gap) else $error("output enable outside read");

  property p_pulse_bound;
    @(posedge mclk_in) disable iff (reset_in) pulse_q <= PULSE_LIM;
  endproperty
  a_pulse_bound: assert property (p_pulse_bound) else $error("too many program pulses");

  property p_retry_bound;
    @(posedge mclk_in) disable iff (reset_in) retry_q <= RETRY_LIM;
  endproperty
  a_retry_bound: assert property (p_retry_bound) else $error("too many erase attempts");

  property p_double_erase;
    @(posedge mclk_in) disable iff (reset_in)
      (state_q == fes_pkg::S_E_START && $changed(state_q)) |-> $past(state_q) == fes_pkg::S_E_SETUP;
  endproperty
  a_double_erase: assert property (p_double_erase) else $error("erase start without setup");

  property p_resume_addr;
    @(posedge mclk_in) disable iff (reset_in)
      (state_q == fes_pkg::S_E_SETUP && $changed(state_q) && $past(state_q) == fes_pkg::S_E_CHECK)
      |-> $stable(addr_q);
  endproperty
  a_resume_addr: assert property (p_resume_addr) else $error("verify address lost on retry");

  property p_read_before_off;
    @(posedge mclk_in) disable iff (reset_in)
      $fell(flash_vpp_en_out) |-> $past(state_q) == fes_pkg::S_DONE;
  endproperty
  a_read_before_off: assert property (p_read_before_off) else $error("supply dropped without read command");
endmodule

// >>> fes_pkg.sv
package fes_pkg;
  // Command codes written to the flash command register, then the zero and erased data bytes.
  localparam logic [7:0] CMD_READ           = 8'h00;
  localparam logic [7:0] CMD_ERASE          = 8'h20;
  localparam logic [7:0] CMD_ERASE_VERIFY   = 8'ha0;
  localparam logic [7:0] CMD_PROGRAM        = 8'h40;
  localparam logic [7:0] CMD_PROGRAM_VERIFY = 8'hc0;
  localparam logic [7:0] DATA_ZERO          = 8'h00;
  localparam logic [7:0] DATA_ERASED        = 8'hff;

  localparam int ADDR_W_DEF         = 16;
  localparam int PROG_LIMIT         = 25;
  localparam int ERASE_LIMIT_GRADE1 = 1000;
  localparam int ERASE_LIMIT_GRADE3 = 6000;
  localparam int CNT_W              = 20;
  localparam int PULSE_W            = 5;
  localparam int RETRY_W            = 13;

  localparam int CLK_PERIOD_NS = 10;
  localparam int T_WP_NS       = 60;
  localparam int T_WC_NS       = 150;
  localparam int T_ACC_NS      = 150;
  localparam int T_VPP_NS      = 100;
  localparam int T_PROG_US     = 10;
  localparam int T_VERIFY_US   = 6;
  localparam int T_ERASE_US    = 9500;

  // Least times, rounded up to whole cycles.
  localparam int WP_CYC     = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WC_CYC     = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC    = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VPP_CYC    = (T_VPP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYC   = (T_PROG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VERIFY_CYC = (T_VERIFY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC  = (T_ERASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_LEN     = ACC_CYC + 3;

  typedef enum logic [4:0] {
    S_IDLE     = 5'h00,
    S_VPP      = 5'h01,
    S_P_SETUP  = 5'h02,
    S_P_DATA   = 5'h03,
    S_P_WAIT   = 5'h04,
    S_P_VCMD   = 5'h05,
    S_P_VWAIT  = 5'h06,
    S_P_READ   = 5'h07,
    S_P_CHECK  = 5'h08,
    S_E_SETUP  = 5'h09,
    S_E_START  = 5'h0a,
    S_E_WAIT   = 5'h0b,
    S_E_VCMD   = 5'h0c,
    S_E_VWAIT  = 5'h0d,
    S_E_READ   = 5'h0e,
    S_E_CHECK  = 5'h0f,
    S_RST_CMD  = 5'h10,
    S_DONE     = 5'h11
  } fes_state_t;
endpackage

// >>> fes_flash_model.sv
`timescale 1ns/100ps
module fes_flash_model #(
  parameter int  AW      = 3,
  parameter real T_ERASE = 200.0
) (
  input  wire logic          vpp_en_in,
  input  wire logic          ce_n_in,
  input  wire logic          oe_n_in,
  input  wire logic          we_n_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [7:0]    dq_in,
  input  wire logic [7:0]    prog_need_in,
  input  wire logic [7:0]    erase_need_in,
  input  wire logic [AW-1:0] stuck_addr_in,
  output logic      [7:0]    dq_out
);
  logic [7:0]    mem [2**AW];
  logic [7:0]    cmd_q   = 8'h00;
  logic [7:0]    cmd_off = 8'h00;
  logic [AW-1:0] a_q;
  logic [AW-1:0] pa_q;
  logic          pre_ok  = 1'b1;
  logic          fresh   = 1'b0;
  logic          t_err   = 1'b0;
  logic          vld     = 1'b0;
  int            n_pulse = 0;
  int            n_erase = 0;
  int            n_evfy  = 0;
  int            pcnt    = 0;
  realtime       t_prog  = 0;
  realtime       t_erase = 0;
  realtime       t_we    = 0;
  realtime       t_oe    = 0;
  wire           wr_n    = ce_n_in | we_n_in;
  wire [7:0]     rd      = (cmd_q == 8'ha0) ? mem[a_q] : (cmd_q == 8'hc0) ? mem[pa_q] : mem[addr_in];

  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
  end

  always @(vpp_en_in) begin
    if (!vpp_en_in) cmd_off = cmd_q;
    cmd_q = 8'h00;
    if (vpp_en_in) begin
      n_pulse = 0;
      n_erase = 0;
      n_evfy = 0;
      pcnt = 0;
      pre_ok = 1'b1;
      fresh = 1'b1;
    end
  end

  always @(negedge wr_n) a_q = addr_in;

  always @(negedge oe_n_in) t_oe = $realtime;

  always @(posedge wr_n) begin
    t_we = $realtime;
    if (vpp_en_in && cmd_q == 8'h40) begin
      if (a_q !== pa_q) pcnt = 0;
      pa_q = a_q;
      pcnt++;
      n_pulse++;
      t_prog = $realtime;
      if (pcnt >= prog_need_in) mem[a_q] = mem[a_q] & dq_in;
      cmd_q = 8'h00;
    end else if (vpp_en_in && cmd_q == 8'h20 && dq_in == 8'h20) begin
      n_erase++;
      t_erase = $realtime;
      foreach (mem[i]) begin
        if (fresh) pre_ok &= (mem[i] === 8'h00);
        if (n_erase >= erase_need_in || i < stuck_addr_in) mem[i] = 8'hff;
      end
      fresh = 1'b0;
      cmd_q = 8'h00;
    end else if (vpp_en_in) begin
      cmd_q = dq_in;
      if (dq_in == 8'ha0) begin
        n_evfy++;
        t_err |= ($realtime - t_erase < T_ERASE);
      end
      if (dq_in == 8'hc0) t_err |= ($realtime - t_prog < 10000.0);
    end
  end

  // Data is shown only after the access time and, in a verify mode, after the settling gap.
  always @(ce_n_in or oe_n_in) begin
    vld = 1'b0;
    #150;
    vld = !ce_n_in && !oe_n_in && (cmd_q == 8'h00 || t_oe - t_we >= 6000.0);
  end

  assign dq_out = vld ? rd : ~rd;
endmodule

// >>> fes_host_bench.sv
`timescale 1ns/100ps
module fes_host_bench;
  localparam int AW    = 3;
  localparam int PMAX  = 5;
  localparam int EMAX  = 3;
  localparam int EWAIT = 20;
  logic          mclk_in      = 1'b0;
  logic          reset_in     = 1'b1;
  logic          clk_en_in    = 1'b1;
  logic          cmd_valid_in = 1'b0;
  logic          cmd_erase_in = 1'b0;
  logic          jitter       = 1'b0;
  logic [AW-1:0] cmd_addr_in  = '0;
  logic [AW-1:0] stuck        = '0;
  logic [7:0]    cmd_data_in  = 8'h00;
  logic [7:0]    pneed        = 8'h01;
  logic [7:0]    eneed        = 8'h01;
  logic [AW-1:0] fail_addr_out, flash_addr_out, a;
  logic [7:0]    flash_dq_out, flash_dq_in, fl_dq, d;
  logic          cmd_ready_out, done_out, fail_out, vpp, ce_n, oe_n, we_n, dq_oe;
  logic [7:0]    exp_mem [2**AW];
  int            seed = 78792;
  int            mismatches = 0;
  int            n_tests = 0;

  assign flash_dq_in = dq_oe ? flash_dq_out : fl_dq;

  fes_host #(.ADDR_W(AW), .PROG_MAX(PMAX), .ERASE_MAX(EMAX), .ERASE_WAIT(EWAIT)) fes_host_inst (
    .mclk_in(mclk_in), .reset_in(reset_in), .clk_en_in(clk_en_in), .cmd_valid_in(cmd_valid_in),
    .cmd_erase_in(cmd_erase_in), .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in),
    .cmd_ready_out(cmd_ready_out), .done_out(done_out), .fail_out(fail_out), .fail_addr_out(fail_addr_out),
    .flash_vpp_en_out(vpp), .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n), .flash_we_n_out(we_n),
    .flash_addr_out(flash_addr_out), .flash_dq_out(flash_dq_out), .flash_dq_oe_out(dq_oe),
    .flash_dq_in(flash_dq_in));

  fes_flash_model #(.AW(AW), .T_ERASE(EWAIT * 10.0)) fes_flash_model_inst (
    .vpp_en_in(vpp), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .addr_in(flash_addr_out),
    .dq_in(flash_dq_in), .prog_need_in(pneed), .erase_need_in(eneed), .stuck_addr_in(stuck),
    .dq_out(fl_dq));

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) clk_en_in <= jitter ? (($random(seed) & 3) != 0) : 1'b1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One request; a second one is offered while busy and must be ignored.
  task automatic run(input logic er, input logic [AW-1:0] ra, input logic [7:0] rdat);
    int k;
    k = 0;
    cmd_valid_in <= 1'b1;
    cmd_erase_in <= er;
    cmd_addr_in <= ra;
    cmd_data_in <= rdat;
    do begin
      @(posedge mclk_in);
      k++;
    end while (!(clk_en_in === 1'b1 && cmd_ready_out === 1'b1) && k < 50);
    if (!(clk_en_in === 1'b1 && cmd_ready_out === 1'b1)) begin
      mismatches++;
      stop_test();
    end
    cmd_addr_in <= ~ra;
    cmd_data_in <= 8'h00;
    @(posedge mclk_in);
    cmd_valid_in <= 1'b0;
    k = 0;
    while (done_out !== 1'b1 && k < 30000) begin
      @(posedge mclk_in);
      k++;
    end
    if (done_out !== 1'b1) begin
      mismatches++;
      stop_test();
    end
    chk(fes_flash_model_inst.t_err, 1'b0);
    chk(fes_flash_model_inst.cmd_off, 8'h00);
    chk(vpp, 1'b0);
  endtask

  initial begin
    repeat (6) @(posedge mclk_in);
    chk({ce_n, oe_n, we_n, vpp, dq_oe, cmd_ready_out, done_out, fail_out}, 8'he4);
    reset_in <= 1'b0;
    foreach (exp_mem[i]) exp_mem[i] = 8'hff;
    jitter = 1'b1;
    for (int i = 0; i < 4; i++) begin
      a = AW'(i * 2 + ($random(seed) & 1));
      d = 8'($random(seed));
      pneed <= (i == 3) ? 8'(PMAX) : 8'(1 + ($random(seed) & 1));
      run(1'b0, a, d);
      exp_mem[a] = exp_mem[a] & d;
      chk(fail_out, 1'b0);
      chk(fes_flash_model_inst.mem[a], exp_mem[a]);
      chk(fes_flash_model_inst.n_pulse, pneed);
    end
    pneed <= 8'(PMAX + 1);
    run(1'b0, a, ~d);
    chk({fail_out, fail_addr_out}, {1'b1, a});
    chk(fes_flash_model_inst.n_pulse, PMAX);
    foreach (exp_mem[i]) chk(fes_flash_model_inst.mem[i], exp_mem[i]);
    jitter = 1'b0;
    pneed <= 8'h01;
    stuck <= AW'(5);
    eneed <= 8'(EMAX + 2);
    run(1'b1, '0, 8'h00);
    chk({fail_out, fail_addr_out}, {1'b1, AW'(5)});
    chk(fes_flash_model_inst.n_erase, EMAX);
    chk(fes_flash_model_inst.n_evfy, 5 + EMAX);
    chk(fes_flash_model_inst.pre_ok, 1'b1);
    stuck <= AW'($random(seed));
    eneed <= 8'(EMAX);
    run(1'b1, '0, 8'h00);
    chk(fail_out, 1'b0);
    chk(fes_flash_model_inst.n_erase, EMAX);
    chk(fes_flash_model_inst.n_evfy, EMAX + 7);
    chk(fes_flash_model_inst.pre_ok, 1'b1);
    foreach (exp_mem[i]) chk(fes_flash_model_inst.mem[i], 8'hff);
    stop_test();
  end
endmodule
